// [t8pwm_pkg.sv]
/*
  Constants, field layouts and enumerations for the 8-bit PWM timer.
  Assumes a single 20 MHz system clock and a plain register port
  (address, write data, write strobe, read strobe, read data next cycle).
*/
package t8pwm_pkg;

  // ==========================================================================
  // Widths and counter limits
  localparam int unsigned ADDR_W  = 3;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PRESC_W = 10;
  localparam logic [7:0]  CNT_MAX    = 8'hFF;
  localparam logic [7:0]  CNT_BOTTOM = 8'h00;
  localparam logic [7:0]  CNT_ONE    = 8'h01;

  // ==========================================================================
  // Register indices
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_COUNT  = 3'h1;
  localparam logic [2:0] REG_CMP    = 3'h2;
  localparam logic [2:0] REG_FLAGS  = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam logic [2:0] REG_CMPACT = 3'h5;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_WAVE_LSB = 0;
  localparam int unsigned CTRL_COM_LSB  = 2;
  localparam int unsigned CTRL_CS_LSB   = 4;
  localparam int unsigned FLAG_OVF_BIT  = 0;
  localparam int unsigned FLAG_CMF_BIT  = 1;
  localparam int unsigned STAT_DOWN_BIT = 0;
  localparam int unsigned STAT_OUT_BIT  = 1;
  localparam int unsigned STAT_PEN_BIT  = 2;

  // ==========================================================================
  // Reset values and prescaler step
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_PRESC = 10'h000;
  localparam logic [9:0] PRESC_STEP = 10'h001;

  // ==========================================================================
  // Prescaler taps: a tick fires when the masked divider bits are all ones
  localparam logic [9:0] PRESC_MASK_8    = 10'h007;
  localparam logic [9:0] PRESC_MASK_64   = 10'h03F;
  localparam logic [9:0] PRESC_MASK_256  = 10'h0FF;
  localparam logic [9:0] PRESC_MASK_1024 = 10'h3FF;

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'b00,
    WAVE_PHASE  = 2'b01,
    WAVE_CTC    = 2'b10,
    WAVE_FAST   = 2'b11
  } t8pwm_wave_t;

  typedef enum logic [1:0] {
    COM_OFF    = 2'b00,
    COM_TOGGLE = 2'b01,
    COM_NONINV = 2'b10,
    COM_INV    = 2'b11
  } t8pwm_com_t;

  typedef enum logic [2:0] {
    CS_STOP   = 3'b000,
    CS_DIV1   = 3'b001,
    CS_DIV8   = 3'b010,
    CS_DIV64  = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1K  = 3'b101,
    CS_EXTF   = 3'b110,
    CS_EXTR   = 3'b111
  } t8pwm_cs_t;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } t8pwm_dir_t;

  typedef struct packed {
    logic [9:0]  presc;
    t8pwm_wave_t wave;
    t8pwm_com_t  com;
    t8pwm_cs_t   cs;
    logic [7:0]  cnt;
    t8pwm_dir_t  dir;
    logic [7:0]  cmp_buf;
    logic [7:0]  cmp_act;
    logic        blk;
    logic        ovf;
    logic        cmf;
    logic        oc;
    logic        pin_en;
    logic [7:0]  rdata;
  } t8pwm_state_t;

endpackage

// [t8pwm_top.sv]
/*
  8-bit timer with fast PWM and phase correct PWM waveform generation.
  Assumes all inputs are synchronous to clk_sys_i, the register master
  follows the one-cycle strobe protocol, and the pin driver outside uses
  the enable to decide whether the compare output reaches the pad.
*/
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module t8pwm_top (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            compare_output_pin_o,
  output logic            compare_output_pin_en_o,
  output logic            overflow_flag_o,
  output logic            compare_match_flag_o
);

  t8pwm_pkg::t8pwm_state_t st_q;
  t8pwm_pkg::t8pwm_state_t st_d;

  logic       timer_tick;
  logic       match;
  logic       match_eff;
  logic       up_match;
  logic       up_level;
  logic       at_max;
  logic       at_bottom;
  logic       ovf_set;
  logic [7:0] flags_rd;
  logic [7:0] status_rd;
  logic [7:0] ctrl_rd;

  // ==========================================================================
  // Timer tick from the free-running prescaler
  // External clock selections are not wired in; they leave the timer stopped.
  always_comb begin
    unique case (st_q.cs)
      t8pwm_pkg::CS_STOP:   timer_tick = 1'b0;
      t8pwm_pkg::CS_DIV1:   timer_tick = 1'b1;
      t8pwm_pkg::CS_DIV8:   timer_tick =
        (st_q.presc & t8pwm_pkg::PRESC_MASK_8) == t8pwm_pkg::PRESC_MASK_8;
      t8pwm_pkg::CS_DIV64:  timer_tick =
        (st_q.presc & t8pwm_pkg::PRESC_MASK_64) == t8pwm_pkg::PRESC_MASK_64;
      t8pwm_pkg::CS_DIV256: timer_tick =
        (st_q.presc & t8pwm_pkg::PRESC_MASK_256) == t8pwm_pkg::PRESC_MASK_256;
      t8pwm_pkg::CS_DIV1K:  timer_tick =
        (st_q.presc & t8pwm_pkg::PRESC_MASK_1024) ==
        t8pwm_pkg::PRESC_MASK_1024;
      t8pwm_pkg::CS_EXTF:   timer_tick = 1'b0;
      t8pwm_pkg::CS_EXTR:   timer_tick = 1'b0;
    endcase
  end

  // ==========================================================================
  // Compare decode
  assign at_max    = st_q.cnt == t8pwm_pkg::CNT_MAX;
  assign at_bottom = st_q.cnt == t8pwm_pkg::CNT_BOTTOM;
  assign match     = timer_tick && !st_q.blk && (st_q.cnt == st_q.cmp_act);
  // Compare at MAX with COM bit 1 set is replaced by the top action
  assign match_eff = match &&
    !((st_q.cmp_act == t8pwm_pkg::CNT_MAX) && st_q.com[1]);
  // The turn at BOTTOM counts as rising, so compare zero stays at one level
  assign up_match  = (st_q.dir == t8pwm_pkg::DIR_UP) || at_bottom;
  assign up_level  = st_q.com[0];
  // Hardware overflow event of this cycle; it beats a software clear
  assign ovf_set   = timer_tick && ((st_q.wave == t8pwm_pkg::WAVE_PHASE) ?
    ((st_q.dir == t8pwm_pkg::DIR_DOWN) && at_bottom) : at_max);

  // ==========================================================================
  // Read views
  always_comb begin
    ctrl_rd = t8pwm_pkg::RST_BYTE;
    ctrl_rd[t8pwm_pkg::CTRL_WAVE_LSB +: 2] = st_q.wave;
    ctrl_rd[t8pwm_pkg::CTRL_COM_LSB +: 2]  = st_q.com;
    ctrl_rd[t8pwm_pkg::CTRL_CS_LSB +: 3]   = st_q.cs;
    flags_rd = t8pwm_pkg::RST_BYTE;
    flags_rd[t8pwm_pkg::FLAG_OVF_BIT] = st_q.ovf;
    flags_rd[t8pwm_pkg::FLAG_CMF_BIT] = st_q.cmf;
    status_rd = t8pwm_pkg::RST_BYTE;
    status_rd[t8pwm_pkg::STAT_DOWN_BIT] = st_q.dir == t8pwm_pkg::DIR_DOWN;
    status_rd[t8pwm_pkg::STAT_OUT_BIT]  = st_q.oc;
    status_rd[t8pwm_pkg::STAT_PEN_BIT]  = st_q.pin_en;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.presc = st_q.presc + t8pwm_pkg::PRESC_STEP;

    // Counting and waveform, only on a timer tick
    if (timer_tick) begin
      st_d.blk = 1'b0;
      if (match) begin
        st_d.cmf = 1'b1;
      end
      unique case (st_q.wave)
        t8pwm_pkg::WAVE_FAST: begin
          if (match_eff) begin
            unique case (st_q.com)
              t8pwm_pkg::COM_OFF:    st_d.oc = st_q.oc;
              t8pwm_pkg::COM_TOGGLE: st_d.oc = !st_q.oc;
              t8pwm_pkg::COM_NONINV: st_d.oc = 1'b0;
              t8pwm_pkg::COM_INV:    st_d.oc = 1'b1;
            endcase
          end
          if (at_max) begin
            st_d.cnt     = t8pwm_pkg::CNT_BOTTOM;
            st_d.ovf     = 1'b1;
            st_d.cmp_act = st_q.cmp_buf;
            if (st_q.com == t8pwm_pkg::COM_NONINV) begin
              st_d.oc = 1'b1;
            end else if (st_q.com == t8pwm_pkg::COM_INV) begin
              st_d.oc = 1'b0;
            end
          end else begin
            st_d.cnt = st_q.cnt + t8pwm_pkg::CNT_ONE;
          end
        end
        t8pwm_pkg::WAVE_PHASE: begin
          if (match_eff && st_q.com[1]) begin
            st_d.oc = up_match ? up_level : !up_level;
          end
          if (st_q.dir == t8pwm_pkg::DIR_UP) begin
            if (at_max) begin
              st_d.dir     = t8pwm_pkg::DIR_DOWN;
              st_d.cnt     = t8pwm_pkg::CNT_MAX - t8pwm_pkg::CNT_ONE;
              st_d.cmp_act = st_q.cmp_buf;
              if (st_q.com[1]) begin
                // Level at MAX follows the newly loaded compare value
                st_d.oc = (st_q.cmp_buf == t8pwm_pkg::CNT_MAX) ?
                  !up_level : up_level;
              end
            end else begin
              st_d.cnt = st_q.cnt + t8pwm_pkg::CNT_ONE;
            end
          end else begin
            if (at_bottom) begin
              st_d.dir = t8pwm_pkg::DIR_UP;
              st_d.cnt = t8pwm_pkg::CNT_ONE;
              st_d.ovf = 1'b1;
            end else begin
              st_d.cnt = st_q.cnt - t8pwm_pkg::CNT_ONE;
            end
          end
        end
        t8pwm_pkg::WAVE_NORMAL,
        t8pwm_pkg::WAVE_CTC: begin
          // Plain up count; non-PWM waveform actions are not provided
          st_d.cnt = st_q.cnt + t8pwm_pkg::CNT_ONE;
          if (at_max) begin
            st_d.ovf = 1'b1;
          end
        end
      endcase
    end

    // Non-PWM modes take the compare value at once
    if (st_q.wave == t8pwm_pkg::WAVE_NORMAL ||
        st_q.wave == t8pwm_pkg::WAVE_CTC) begin
      st_d.cmp_act = st_q.cmp_buf;
      st_d.dir     = t8pwm_pkg::DIR_UP;
    end
    if (st_q.wave == t8pwm_pkg::WAVE_FAST) begin
      st_d.dir = t8pwm_pkg::DIR_UP;
    end

    // Register writes; flag set above wins over a clear here
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        t8pwm_pkg::REG_CTRL: begin
          st_d.wave = t8pwm_pkg::t8pwm_wave_t'(
            reg_wdata_i[t8pwm_pkg::CTRL_WAVE_LSB +: 2]);
          st_d.com  = t8pwm_pkg::t8pwm_com_t'(
            reg_wdata_i[t8pwm_pkg::CTRL_COM_LSB +: 2]);
          st_d.cs   = t8pwm_pkg::t8pwm_cs_t'(
            reg_wdata_i[t8pwm_pkg::CTRL_CS_LSB +: 3]);
        end
        t8pwm_pkg::REG_COUNT: begin
          // A counter write hides the compare on the next tick
          st_d.cnt = reg_wdata_i;
          st_d.blk = 1'b1;
        end
        t8pwm_pkg::REG_CMP: begin
          st_d.cmp_buf = reg_wdata_i;
        end
        t8pwm_pkg::REG_FLAGS: begin
          if (reg_wdata_i[t8pwm_pkg::FLAG_OVF_BIT] && !ovf_set) begin
            st_d.ovf = 1'b0;
          end
          if (reg_wdata_i[t8pwm_pkg::FLAG_CMF_BIT] && !match) begin
            st_d.cmf = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    st_d.pin_en = st_d.com != t8pwm_pkg::COM_OFF;

    // Read data stands only in the cycle after the strobe
    st_d.rdata = t8pwm_pkg::RST_BYTE;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        t8pwm_pkg::REG_CTRL:   st_d.rdata = ctrl_rd;
        t8pwm_pkg::REG_COUNT:  st_d.rdata = st_q.cnt;
        t8pwm_pkg::REG_CMP:    st_d.rdata = st_q.cmp_buf;
        t8pwm_pkg::REG_FLAGS:  st_d.rdata = flags_rd;
        t8pwm_pkg::REG_STATUS: st_d.rdata = status_rd;
        t8pwm_pkg::REG_CMPACT: st_d.rdata = st_q.cmp_act;
        default:               st_d.rdata = t8pwm_pkg::RST_BYTE;
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_q.presc   <= t8pwm_pkg::RST_PRESC;
      st_q.wave    <= t8pwm_pkg::WAVE_NORMAL;
      st_q.com     <= t8pwm_pkg::COM_OFF;
      st_q.cs      <= t8pwm_pkg::CS_STOP;
      st_q.cnt     <= t8pwm_pkg::RST_BYTE;
      st_q.dir     <= t8pwm_pkg::DIR_UP;
      st_q.cmp_buf <= t8pwm_pkg::RST_BYTE;
      st_q.cmp_act <= t8pwm_pkg::RST_BYTE;
      st_q.blk     <= 1'b0;
      st_q.ovf     <= 1'b0;
      st_q.cmf     <= 1'b0;
      st_q.oc      <= 1'b0;
      st_q.pin_en  <= 1'b0;
      st_q.rdata   <= t8pwm_pkg::RST_BYTE;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o             = st_q.rdata;
  assign compare_output_pin_o    = st_q.oc;
  assign compare_output_pin_en_o = st_q.pin_en;
  assign overflow_flag_o         = st_q.ovf;
  assign compare_match_flag_o    = st_q.cmf;

endmodule

// [t8pwm_load.sv]
/*
  Model of the load on the PWM pin: counts cycles the pin is driven high.
  Assumes the pin is sampled on clk_sys_i and only counts while enabled.
*/
`timescale 1ns/1ps
module t8pwm_load (
  input  wire logic        clk_sys_i,
  input  wire logic        pin_i,
  input  wire logic        pin_en_i,
  input  wire logic        clr_i,
  output logic      [15:0] high_o
);
  // ==========================================================================
  // Duty integrator; an undriven pin adds nothing
  always_ff @(posedge clk_sys_i) begin
    if (clr_i) begin
      high_o <= 16'h0000;
    end else if (pin_en_i && pin_i) begin
      high_o <= high_o + 16'h0001;
    end
  end
endmodule

// [t8pwm_checker.sv]
/*
  Port assertions for the PWM timer, bound to t8pwm_top.
  Assumes one clock and the one-cycle strobe register port.
*/
`timescale 1ns/1ps
module t8pwm_checker (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       compare_output_pin_o,
  input wire logic       compare_output_pin_en_o,
  input wire logic       overflow_flag_o,
  input wire logic       compare_match_flag_o
);
  logic [7:0] ctrl_q;
  logic [9:0] gap_q;
  logic [9:0] quiet_q;
  logic       pin_q;
  logic       rise_w;
  logic       steady_w;
  logic       clr_w;
  // ==========================================================================
  // Shadow control and pulse spacing; long quiet avoids buffer reloads
  assign rise_w = compare_output_pin_o && !pin_q;
  assign steady_w = quiet_q == 10'h3FF && ctrl_q[6:4] == 3'h1
                    && ctrl_q[3] && ctrl_q[0];
  assign clr_w = reg_wr_i && reg_addr_i == t8pwm_pkg::REG_FLAGS;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q <= 8'h00;
      gap_q <= 10'h000;
      quiet_q <= 10'h000;
      pin_q <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == t8pwm_pkg::REG_CTRL) begin
        ctrl_q <= reg_wdata_i;
      end
      quiet_q <= reg_wr_i ? 10'h000 : quiet_q + {9'h000, quiet_q != 10'h3FF};
      gap_q <= rise_w ? 10'h001 : gap_q + {9'h000, gap_q != 10'h3FF};
      pin_q <= compare_output_pin_o;
    end
  end
  // ==========================================================================
  // Assertions
  a_read_slot: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_rdata_o != 8'h00 |-> $past(reg_rd_i)) else $error("stray read data");
  a_unmapped_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i > 3'h5 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (@(posedge clk_sys_i) !rst_n_i |=>
    !compare_output_pin_o && !compare_output_pin_en_o && !overflow_flag_o
    && !compare_match_flag_o) else $error("outputs active after reset");
  a_pin_enable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == t8pwm_pkg::REG_CTRL |=> compare_output_pin_en_o
    == (($past(reg_wdata_i) & 8'h0C) != 8'h00)) else $error("pin enable wrong");
  a_ovf_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    overflow_flag_o && !(clr_w && reg_wdata_i[0]) |=> overflow_flag_o)
    else $error("overflow flag lost");
  a_match_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    compare_match_flag_o && !(clr_w && reg_wdata_i[1]) |=> compare_match_flag_o)
    else $error("match flag lost");
  a_ovf_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clr_w && reg_wdata_i[0] && ctrl_q[6:4] == 3'h0 |=> !overflow_flag_o)
    else $error("overflow flag not cleared");
  a_status_view: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == t8pwm_pkg::REG_STATUS |=> reg_rdata_o[2:1] ==
    {$past(compare_output_pin_en_o), $past(compare_output_pin_o)})
    else $error("status does not match pin");
  a_pwm_period: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rise_w && steady_w |-> gap_q == (ctrl_q[1] ? 10'h100 : 10'h1FE))
    else $error("pwm period wrong");
  c_fast_pwm: cover property (@(posedge clk_sys_i) rise_w && steady_w && ctrl_q[1]);
  c_phase_pwm: cover property (@(posedge clk_sys_i) rise_w && steady_w && !ctrl_q[1]);
  c_overflow: cover property (@(posedge clk_sys_i) $rose(overflow_flag_o));
endmodule

bind t8pwm_top t8pwm_checker u_chk (.clk_sys_i, .rst_n_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .compare_output_pin_o,
  .compare_output_pin_en_o, .overflow_flag_o, .compare_match_flag_o);

// [testbench.sv]
/*
  Self-checking bench for the PWM timer: register port tasks, duty checks
  through the load model. Assumes a 20 MHz clock and fixed seed 32'h2237.
*/
`timescale 1ns/1ps
module testbench;
  logic        clk_sys_i   = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic [2:0]  reg_addr_i  = 3'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic        clr         = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic        compare_output_pin_o;
  logic        compare_output_pin_en_o;
  logic        overflow_flag_o;
  logic        compare_match_flag_o;
  logic [15:0] high;
  logic [7:0]  v;
  int          failures    = 0;
  int          check_count = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  t8pwm_top dut (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .compare_output_pin_o, .compare_output_pin_en_o,
    .overflow_flag_o, .compare_match_flag_o);
  t8pwm_load load (.clk_sys_i, .pin_i(compare_output_pin_o),
    .pin_en_i(compare_output_pin_en_o), .clr_i(clr), .high_o(high));

  // ==========================================================================
  // Tasks
  task automatic final_report;
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    // Idle cycle, so a following call never re-raises the strobe at once
    @(posedge clk_sys_i);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
    chk({8'h00, v}, {8'h00, e});
    @(posedge clk_sys_i);
  endtask
  // Expected high cycles in a window of four fast or two phase periods
  function automatic logic [15:0] exp_high(input logic [1:0] w, m,
                                           input logic [7:0] c);
    logic [15:0] h;
    if (m == t8pwm_pkg::COM_TOGGLE) return 16'h0200;
    if (w == t8pwm_pkg::WAVE_FAST) h = 16'h0004 * ({8'h00, c} + 16'h0001);
    else h = 16'h0004 * {8'h00, c};
    if (m == t8pwm_pkg::COM_INV) begin
      h = (w == t8pwm_pkg::WAVE_FAST ? 16'h0400 : 16'h03FC) - h;
    end
    return h;
  endfunction
  task automatic run(input logic [1:0] w, m, input logic [7:0] c,
                     input logic [2:0] cs);
    logic [15:0] dv;
    dv = (cs == t8pwm_pkg::CS_DIV8) ? 16'h0008 : 16'h0001;
    wr(t8pwm_pkg::REG_CMP, c);
    wr(t8pwm_pkg::REG_CTRL, {1'b0, cs, m, w});
    repeat (2200 * dv) @(posedge clk_sys_i);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    repeat ((w == t8pwm_pkg::WAVE_FAST ? 1024 : 1020) * dv) @(posedge clk_sys_i);
    #1 chk(high, exp_high(w, m, c) * dv);
    @(posedge clk_sys_i);
  endtask

  // ==========================================================================
  // Watchdog: generous bound over the planned runs
  initial begin
    repeat (95000) @(posedge clk_sys_i);
    failures++;
    final_report();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] c;
    logic [7:0] cv [3];
    void'($urandom(32'h2237));
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int a = 0; a < 8; a++) rc(a[2:0], 8'h00);
    wr(3'h6, 8'hA5);
    rc(3'h6, 8'h00);
    c = 8'($urandom()) & 8'h7F;
    wr(t8pwm_pkg::REG_CTRL, c);
    rc(t8pwm_pkg::REG_CTRL, c);
    // Stopped timer never reaches the top, so the buffer must not load
    wr(t8pwm_pkg::REG_CTRL, 8'h0B);
    wr(t8pwm_pkg::REG_CMP, 8'h5A);
    rc(t8pwm_pkg::REG_CMPACT, 8'h00);
    wr(t8pwm_pkg::REG_COUNT, 8'hFD);
    wr(t8pwm_pkg::REG_FLAGS, 8'h03);
    wr(t8pwm_pkg::REG_CTRL, 8'h1B);
    rc(t8pwm_pkg::REG_FLAGS, 8'h00);
    rc(t8pwm_pkg::REG_FLAGS, 8'h01);
    rc(t8pwm_pkg::REG_FLAGS, 8'h01);
    rc(t8pwm_pkg::REG_CMPACT, 8'h5A);
    wr(t8pwm_pkg::REG_CTRL, 8'h09);
    wr(t8pwm_pkg::REG_COUNT, 8'hFD);
    wr(t8pwm_pkg::REG_FLAGS, 8'h03);
    wr(t8pwm_pkg::REG_CTRL, 8'h19);
    repeat (20) @(posedge clk_sys_i);
    rc(t8pwm_pkg::REG_FLAGS, 8'h00);
    rc(t8pwm_pkg::REG_STATUS, 8'h05);
    repeat (300) @(posedge clk_sys_i);
    rc(t8pwm_pkg::REG_FLAGS, 8'h03);
    chk({14'h0000, compare_match_flag_o, overflow_flag_o}, 16'h0003);
    cv[0] = 8'h00;
    cv[1] = 8'hFF;
    cv[2] = 8'($urandom());
    foreach (cv[i]) begin
      for (int k = 0; k < 4; k++) begin
        run(k[1] ? t8pwm_pkg::WAVE_FAST : t8pwm_pkg::WAVE_PHASE,
            k[0] ? t8pwm_pkg::COM_INV : t8pwm_pkg::COM_NONINV, cv[i], 3'h1);
      end
    end
    run(t8pwm_pkg::WAVE_FAST, t8pwm_pkg::COM_TOGGLE, cv[2], 3'h1);
    repeat (3) begin
      run($urandom_range(1) ? t8pwm_pkg::WAVE_FAST : t8pwm_pkg::WAVE_PHASE,
          2'h2 + 2'($urandom_range(1)), 8'($urandom()), 3'h1);
    end
    run(t8pwm_pkg::WAVE_FAST, t8pwm_pkg::COM_NONINV, cv[2], 3'h2);
    final_report();
  end
endmodule
